// ---- design/wdld_cfg.svh ----
// offsets, field positions, keys and timing for the watchdog block
`ifndef WDLD_CFG_SVH
`define WDLD_CFG_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define WDLD_OFF_CTRL    8'h00
`define WDLD_OFF_SVC     8'h04
`define WDLD_OFF_TO      8'h08
`define WDLD_OFF_CNT     8'h0c
`define WDLD_OFF_STAT    8'h10

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define WDLD_CTRL_EN     0
`define WDLD_CTRL_LOCK   4
`define WDLD_STAT_LOCK   0
`define WDLD_STAT_FORCE  1
`define WDLD_STAT_KEY1   2

// ------------------------------------------------------------
// unlock keys, written to the service code field
// ------------------------------------------------------------
`define WDLD_KEY1        16'hc520
`define WDLD_KEY2        16'hd928

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define WDLD_OSC_KHZ     128
`define WDLD_TIMEOUT_MS  10
`define WDLD_TO_DEF      (`WDLD_TIMEOUT_MS * `WDLD_OSC_KHZ)
`define WDLD_INIT_WAIT   2'h3

`endif

// ---- design/wdld_pkg.sv ----
// types shared by the watchdog block
package wdld_pkg;
    typedef enum logic [1:0] {
        WDLD_KEY_IDLE = 2'b01,
        WDLD_KEY_GOT1 = 2'b10
    } wdld_key_e;

    typedef logic [31:0] wdld_word_t;
endpackage : wdld_pkg

// ---- design/wdld_osc_tick.sv ----
// slow oscillator synchroniser and rising edge tick
`timescale 1ns/1ps
module wdld_osc_tick (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic osc_pin,
    output logic      tick
);
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic tick_ff;
    wire  nxt_tick = sync2_ff & ~sync3_ff;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            tick_ff  <= 1'b0;
        end else if (ce) begin
            sync1_ff <= osc_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            tick_ff  <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule : wdld_osc_tick

// ---- design/wdld_top.sv ----
// watchdog with soft lock, key unlock and strap controlled enable
// Function
// - counter steps on slow oscillator edges only
// - default timeout is about 10 ms
// - expiry while enabled requests system reset
// - keys c520 then d928 clear lock
// - clearing enable when unlocked stops watchdog, unless a missing boot config word holds enable set
// - option bit msb sets enable at reset
// - strap-disabled watchdog can be enabled later
// - missing boot config word forces enable
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "wdld_cfg.svh"
module wdld_top (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        slow_internal_osc,
    input  wire logic        nvuo_msb,
    input  wire logic        boot_no_reset_config_half_word,
    output logic             sys_reset_req,
    output logic             wdg_enabled
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    wdld_pkg::wdld_word_t  prdata_ff;
    wdld_pkg::wdld_word_t  nxt_prdata;
    wdld_pkg::wdld_word_t  to_ff;
    wdld_pkg::wdld_word_t  cnt_ff;
    wdld_pkg::wdld_key_e   key_ff;
    wdld_pkg::wdld_key_e   nxt_key;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic                  en_ff;
    logic                  nxt_en;
    logic                  lock_ff;
    logic                  nxt_lock;
    logic                  force_ff;
    logic                  rst_req_ff;
    logic                  init_done_ff;
    logic [1:0]            init_cnt_ff;
    logic                  nvuo_s1_ff;
    logic                  nvuo_s2_ff;
    logic                  osc_tick;

    // ------------------------------------------------------------
    // slow oscillator tick
    // ------------------------------------------------------------
    wdld_osc_tick u_tick (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .ce      (ce),
        .osc_pin (slow_internal_osc),
        .tick    (osc_tick)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc_wait  = psel & penable & ~pready_ff;
    wire acc_done  = psel & penable & pready_ff;
    wire hit_ctrl  = (paddr == `WDLD_OFF_CTRL);
    wire hit_svc   = (paddr == `WDLD_OFF_SVC);
    wire hit_to    = (paddr == `WDLD_OFF_TO);
    wire hit_cnt   = (paddr == `WDLD_OFF_CNT);
    wire hit_stat  = (paddr == `WDLD_OFF_STAT);
    wire hit_any   = hit_ctrl | hit_svc | hit_to | hit_cnt | hit_stat;
    wire wr_ctrl   = ce & acc_done & pwrite & hit_ctrl;
    wire wr_svc    = ce & acc_done & pwrite & hit_svc;
    wire wr_to     = ce & acc_done & pwrite & hit_to;
    wire [15:0] svc_code = pwdata[15:0];
    wire key1_hit  = wr_svc & (svc_code == `WDLD_KEY1);
    wire key2_hit  = wr_svc & (svc_code == `WDLD_KEY2)
                   & (key_ff == wdld_pkg::WDLD_KEY_GOT1);
    wire ctrl_ok   = wr_ctrl & ~lock_ff;
    wire to_ok     = wr_to & ~lock_ff;

    wire [31:0] rd_ctrl = {27'h0, lock_ff, 3'h0, en_ff};
    wire [31:0] rd_stat = {29'h0, (key_ff == wdld_pkg::WDLD_KEY_GOT1),
                           force_ff, lock_ff};

    always_comb begin
        nxt_prdata = 32'h0;
        if (hit_ctrl) nxt_prdata = rd_ctrl;
        if (hit_to)   nxt_prdata = to_ff;
        if (hit_cnt)  nxt_prdata = cnt_ff;
        if (hit_stat) nxt_prdata = rd_stat;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else if (ce) begin
            pready_ff  <= acc_wait;
            pslverr_ff <= acc_wait & ~hit_any;
            prdata_ff  <= (acc_wait & ~pwrite) ? nxt_prdata : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // option strap capture after reset release
    // ------------------------------------------------------------
    wire init_cap = ce & ~init_done_ff & (init_cnt_ff == `WDLD_INIT_WAIT);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nvuo_s1_ff   <= 1'b0;
            nvuo_s2_ff   <= 1'b0;
            init_cnt_ff  <= 2'h0;
            init_done_ff <= 1'b0;
        end else if (ce) begin
            nvuo_s1_ff <= nvuo_msb;
            nvuo_s2_ff <= nvuo_s1_ff;
            if (!init_done_ff)
                init_cnt_ff <= init_cnt_ff + 2'h1;
            if (init_cap)
                init_done_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // unlock key sequence and lock
    // ------------------------------------------------------------
    always_comb begin
        nxt_key = key_ff;
        if (wr_svc) begin
            nxt_key = key1_hit ? wdld_pkg::WDLD_KEY_GOT1
                               : wdld_pkg::WDLD_KEY_IDLE;
        end
    end

    always_comb begin
        nxt_lock = lock_ff;
        if (key2_hit)
            nxt_lock = 1'b0;
        else if (ctrl_ok && pwdata[`WDLD_CTRL_LOCK])
            nxt_lock = 1'b1;
    end

    // ------------------------------------------------------------
    // enable
    // ------------------------------------------------------------
    always_comb begin
        nxt_en = en_ff;
        case (1'b1)
            init_cap:     nxt_en = nvuo_s2_ff | boot_no_reset_config_half_word;
            (boot_no_reset_config_half_word & init_done_ff): nxt_en = 1'b1;
            ctrl_ok:      nxt_en = pwdata[`WDLD_CTRL_EN];
            default:      nxt_en = en_ff;
        endcase
    end

    wire en_rise = nxt_en & ~en_ff;
    wire reload  = en_rise | key2_hit | to_ok;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            key_ff   <= wdld_pkg::WDLD_KEY_IDLE;
            lock_ff  <= 1'b1;
            en_ff    <= 1'b0;
            force_ff <= 1'b0;
        end else if (ce) begin
            key_ff   <= nxt_key;
            lock_ff  <= nxt_lock;
            en_ff    <= nxt_en;
            if (boot_no_reset_config_half_word)
                force_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // timeout counter and reset request
    // ------------------------------------------------------------
    wire [31:0] to_def  = 32'(`WDLD_TO_DEF);
    wire [31:0] nxt_to  = to_ok ? pwdata : to_ff;
    wire        expire  = en_ff & osc_tick & (cnt_ff == 32'h0);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            to_ff      <= 32'(`WDLD_TO_DEF);
            cnt_ff     <= 32'(`WDLD_TO_DEF);
            rst_req_ff <= 1'b0;
        end else if (ce) begin
            to_ff <= nxt_to;
            if (reload)
                cnt_ff <= nxt_to;
            else if (en_ff && osc_tick && cnt_ff != 32'h0)
                cnt_ff <= cnt_ff - 32'h1;
            if (expire && !reload)
                rst_req_ff <= 1'b1;
        end
    end

    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign sys_reset_req = rst_req_ff;
    assign wdg_enabled   = en_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_key1;
        ce && key1_hit;
    endsequence
    sequence s_key2;
        ce && wr_svc && svc_code == `WDLD_KEY2;
    endsequence

    chk_tick_step: assert property (
        (ce && en_ff && !osc_tick && !reload) |=> $stable(cnt_ff))
        else $error("counter moved without oscillator tick");
    chk_default_to: assert property (
        $rose(init_done_ff) |-> to_ff == to_def || !lock_ff)
        else $error("timeout not at default after reset");
    chk_expiry_rst: assert property (
        (expire && !reload && ce) |=> sys_reset_req)
        else $error("expiry did not request reset");
    chk_key_unlock: assert property (
        (s_key1 ##1 ((!wr_svc)[*2] or (!wr_svc)[*3]) ##1 s_key2)
            |=> !lock_ff)
        else $error("key pair did not clear lock");
    chk_disable_stop: assert property (
        (!en_ff && !sys_reset_req && !boot_no_reset_config_half_word && !init_cap)
            |=> !sys_reset_req)
        else $error("disabled watchdog requested reset");
    chk_strap_en: assert property (
        (init_cap && !nvuo_s2_ff && !boot_no_reset_config_half_word) |=> !en_ff)
        else $error("cleared option bit left watchdog on");
    chk_late_enable: assert property (
        (ctrl_ok && pwdata[`WDLD_CTRL_EN] && !init_cap) |=> en_ff)
        else $error("software enable ignored");
    chk_boot_force: assert property (
        (ce && boot_no_reset_config_half_word && (init_done_ff || init_cap)) |=> en_ff)
        else $error("missing boot word did not force enable");
    chk_lock_hold: assert property (
        (wr_ctrl && lock_ff && !boot_no_reset_config_half_word && !init_cap)
            |=> $stable(en_ff) && lock_ff)
        else $error("locked control write took effect");
    chk_apb_wait: assert property (
        (ce && acc_wait) |=> pready ##1 !pready)
        else $error("apb ready not one cycle after wait");
    chk_unmapped_err: assert property (
        (ce && acc_wait && !hit_any) |=> pready && pslverr)
        else $error("unmapped access without error");
    chk_idle_rdata: assert property (
        !pready |-> prdata == 32'h0)
        else $error("read data shown outside ready");
    chk_req_sticky: assert property (
        sys_reset_req |=> sys_reset_req)
        else $error("reset request dropped before reset");
    chk_off_frozen: assert property (
        (ce && !en_ff && !reload) |=> $stable(cnt_ff))
        else $error("disabled counter moved");
    chk_to_locked: assert property (
        (wr_to && lock_ff) |=> $stable(to_ff))
        else $error("locked timeout write took effect");
    chk_en_reload: assert property (
        $rose(en_ff) |-> cnt_ff == to_ff)
        else $error("counter not reloaded on enable");

    // ------------------------------------------------------------
    // check helper: oscillator ticks since the last reload
    // ------------------------------------------------------------
    logic [31:0] chk_ticks_ff;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chk_ticks_ff <= 32'h0;
        end else if (ce && reload) begin
            chk_ticks_ff <= 32'h0;
        end else if (ce && en_ff && osc_tick) begin
            chk_ticks_ff <= chk_ticks_ff + 32'h1;
        end
    end

    // first expiry comes on tick number timeout plus one
    chk_expiry_count: assert property (
        (ce && expire && !reload && !sys_reset_req)
            |-> chk_ticks_ff == to_ff)
        else $error("expiry after wrong number of ticks");
endmodule : wdld_top

// ---- sim/wdld_tb.sv ----
// self-checking bench for the watchdog block
`timescale 1ns/1ps
`include "wdld_cfg.svh"
module testbench;
    logic        mclk    = 1'b0;
    logic        arst_n  = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_pin = 1'b0;
    logic        nvuo    = 1'b1;
    logic        boot    = 1'b0;
    logic        ce      = 1'b1;
    logic        sys_req;
    logic        wdg_en;
    int          n_mismatch = 0;
    int          checked    = 0;
    int          cyc        = 0;
    logic [31:0] q;
    logic        e;

    wdld_top wdld_top_i (
        .mclk              (mclk),
        .arst_n            (arst_n),
        .ce                (ce),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .slow_internal_osc (osc_pin),
        .nvuo_msb          (nvuo),
        .boot_no_reset_config_half_word      (boot),
        .sys_reset_req     (sys_req),
        .wdg_enabled       (wdg_en)
    );

    always #20 mclk = ~mclk;

    // ----------------------------------------------------------------
    // closing report and hang guard
    // ----------------------------------------------------------------
    task wrap_up;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // ----------------------------------------------------------------
    // apb master, waits for pready sampled at a rising edge
    // ----------------------------------------------------------------
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        if (n >= 50) begin
            n_mismatch++;
            wrap_up();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] a, input string name, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(name, q, x);
    endtask : rd

    task osc(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            osc_pin <= 1'b1;
            repeat (4) @(posedge mclk);
            osc_pin <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask : osc

    task do_reset(input logic nv, input logic bt);
        @(posedge mclk);
        arst_n <= 1'b0;
        nvuo   <= nv;
        boot   <= bt;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask : do_reset

    task unlock;
        apb(1'b1, `WDLD_OFF_SVC, {16'h0, `WDLD_KEY1});
        apb(1'b1, `WDLD_OFF_SVC, {16'h0, `WDLD_KEY2});
    endtask : unlock

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset(1'b1, 1'b0);
        rd(`WDLD_OFF_TO, "timeout", 32'h500);
        rd(`WDLD_OFF_CTRL, "ctrl", 32'h11);
        apb(1'b1, `WDLD_OFF_CTRL, 32'h0);
        rd(`WDLD_OFF_CTRL, "ctrl locked", 32'h11);
        apb(1'b0, 8'h20, 32'h0);
        check("slverr", {31'h0, e}, 32'h1);
        unlock();
        rd(`WDLD_OFF_STAT, "status", 32'h0);
        apb(1'b1, `WDLD_OFF_TO, 32'h5);
        osc(2);
        rd(`WDLD_OFF_CNT, "count", 32'h3);
        ce <= 1'b0;
        osc(2);
        ce <= 1'b1;
        rd(`WDLD_OFF_CNT, "count held", 32'h3);
        apb(1'b1, `WDLD_OFF_CTRL, 32'h0);
        osc(10);
        check("req off", {31'h0, sys_req}, 32'h0);
        check("en off", {31'h0, wdg_en}, 32'h0);
        rd(`WDLD_OFF_CNT, "count frozen", 32'h3);
        apb(1'b1, `WDLD_OFF_CTRL, 32'h1);
        osc(5);
        check("req early", {31'h0, sys_req}, 32'h0);
        osc(1);
        check("req expiry", {31'h0, sys_req}, 32'h1);
        do_reset(1'b0, 1'b0);
        check("req cleared", {31'h0, sys_req}, 32'h0);
        rd(`WDLD_OFF_CTRL, "ctrl strap off", 32'h10);
        unlock();
        apb(1'b1, `WDLD_OFF_CTRL, 32'h1);
        @(posedge mclk);
        check("late enable", {31'h0, wdg_en}, 32'h1);
        apb(1'b1, `WDLD_OFF_CTRL, 32'h11);
        apb(1'b1, `WDLD_OFF_CTRL, 32'h0);
        apb(1'b1, `WDLD_OFF_TO, 32'h7);
        rd(`WDLD_OFF_CTRL, "ctrl relocked", 32'h11);
        rd(`WDLD_OFF_TO, "timeout locked", 32'h500);
        do_reset(1'b0, 1'b1);
        check("forced en", {31'h0, wdg_en}, 32'h1);
        rd(`WDLD_OFF_STAT, "status force", 32'h3);
        wrap_up();
    end
endmodule : testbench
